//--- hw/card_status_change_flags.sv
// Status-change flag logic and its configuration registers for one socket
`default_nettype none
// Operation
// - Flag register bits 7 to 4 always read zero.
// - Bit 3 sets on any change of either card-detect input.
// - Memory card: bit 2 sets on a ready low-to-high transition.
// - I/O card: ready flag bit 2 forced to read zero.
// - Memory card: bit 1 sets on battery-low warning from the card.
// - I/O card: battery-warning flag bit 1 forced to read zero.
// - Memory card: bit 0 shows the status-change line level, battery dead.
// - Ring mode: bit 0 shows present ring-indicate line state.
// - Writable configuration register routes and masks status-change sources.
// - Configuration decoded at base plus 805h, legacy 05h or 45h.
// - Masked source reads zero; enabled active source sets its flag.
// - Flags clear on read or on write-one, chosen by global mode bit.
// - Ring operation only when control register bit 7 is set.
// - Card kind from control bit 5: 0 memory, 1 I/O.
module card_status_change_flags
    import csc_flags_pkg::*;
#(
    parameter bit SOCKET_B = 1'b0
)(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    // Register access port
    input  wire logic        i_reg_legacy,
    input  wire logic [11:0] i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    output logic             o_reg_ack,
    // Card lines
    input  wire logic        i_card_detect1_n,
    input  wire logic        i_card_detect2_n,
    input  wire logic        i_ready,
    input  wire logic        i_battery_warn_n,
    input  wire logic        i_stschg_ring_n,
    // Interrupt request and routing
    output logic             o_card_status_change_irq,
    output logic             o_status_irq_to_host_bus,
    output logic      [3:0]  o_irq_select
);

    localparam logic [7:0] IDX_OFS = SOCKET_B ? IDX_SOCKET_B : 8'h00;

    logic [4:0] sync1_q, sync2_q, last_q;
    logic [4:0] sync1_d, sync2_d, last_d;
    logic [7:0] ctrl_q, ctrl_d, cfg_q, cfg_d, glob_q, glob_d;
    logic [3:1] flag_q, flag_d;
    logic [7:0] rdata_q, rdata_d;
    logic       ack_q, ack_d, irq_q, irq_d;
    logic [7:0] status;
    logic       hit_ctrl, hit_flags, hit_cfg, hit_glob;
    logic       io_card, ring_on, level0;
    logic [3:1] set, clr;

    function automatic logic hit(input logic        legacy,
                                 input logic [11:0] addr,
                                 input logic [11:0] off,
                                 input logic [7:0]  idx);
        // Legacy index only spans the low byte, so the upper nibble must be clear
        hit = legacy ? (addr[7:0] == (idx | IDX_OFS)) && (addr[11:8] == 4'h0)
                     : (addr == off);
    endfunction : hit

    // Window and legacy decode
    // Bus signals go in as arguments so each decode follows every bus change
    assign hit_ctrl  = hit(i_reg_legacy, i_reg_addr, OFF_INT_GEN_CTRL, IDX_INT_GEN_CTRL);
    assign hit_flags = hit(i_reg_legacy, i_reg_addr, OFF_CSC_FLAGS, IDX_CSC_FLAGS);
    assign hit_cfg   = hit(i_reg_legacy, i_reg_addr, OFF_CSC_CONFIG, IDX_CSC_CONFIG);
    assign hit_glob  = hit(i_reg_legacy, i_reg_addr, OFF_GLOBAL_CTRL, IDX_GLOBAL_CTRL);

    assign io_card = ctrl_q[BIT_SOCKET_CARD_KIND];
    assign ring_on = ctrl_q[BIT_RING_FUNCTION_ENABLE];
    // Live line level; same pin carries ring in ring mode
    assign level0  = (ring_on || !io_card) && !sync2_q[4];

    always_comb
    begin
        // Only the second stage feeds edge logic, first stage is metastability guard
        // Input synchroniser
        sync1_d = {i_stschg_ring_n, i_battery_warn_n, i_ready, i_card_detect2_n,
                   i_card_detect1_n};
        sync2_d = sync1_q;
        last_d  = sync2_q;
    end

    always_comb
    begin
        status = 8'h00;
        // Card detect change, masked sources read zero
        status[BIT_CARD_DETECT_CHANGE] = flag_q[3] && cfg_q[BIT_CARD_DETECT_CHANGE];
        // I/O card forces bits 2 and 1 to zero
        status[BIT_READY_RISE]  = flag_q[2] && cfg_q[BIT_READY_RISE] && !io_card;
        status[BIT_BATTERY_LOW] = flag_q[1] && cfg_q[BIT_BATTERY_LOW] && !io_card;
        // Bit 0 is a live level, not latched
        status[BIT_BATTERY_DEAD] = level0 && cfg_q[BIT_BATTERY_DEAD];
    end

    always_comb
    begin
        set[3] = (sync2_q[0] != last_q[0]) || (sync2_q[1] != last_q[1]);
        // Ready rising edge, memory card only
        set[2] = sync2_q[2] && !last_q[2] && !io_card;
        // Battery warning asserted, memory card only
        set[1] = !sync2_q[3] && !io_card;
        set    = set & cfg_q[3:1];
        clr    = 3'h0;
        if (glob_q[BIT_CLEAR_MODE_W1C])
        begin
            if (i_reg_wr && hit_flags)
            begin
                clr = i_reg_wdata[3:1];
            end
        end
        else if (i_reg_rd && hit_flags)
        begin
            clr = 3'h7;
        end
        // Sticky, and a set in the clear cycle wins
        flag_d = (flag_q & ~clr) | set;
        // Storage cleared while I/O card so a stale flag cannot reappear later
        if (io_card)
        begin
            flag_d[2:1] = 2'h0;
        end
    end

    always_comb
    begin
        ctrl_d  = ctrl_q;
        cfg_d   = cfg_q;
        glob_d  = glob_q;
        rdata_d = rdata_q;
        ack_d   = i_reg_wr || i_reg_rd;
        if (i_reg_wr)
        begin
            if (hit_ctrl)
            begin
                ctrl_d = i_reg_wdata;
            end
            if (hit_cfg)
            begin
                cfg_d = i_reg_wdata;
            end
            if (hit_glob)
            begin
                glob_d = i_reg_wdata;
            end
        end
        if (i_reg_rd)
        begin
            // Unmapped offsets read zero
            rdata_d = hit_ctrl  ? ctrl_q :
                      hit_cfg   ? cfg_q  :
                      hit_glob  ? glob_q :
                      hit_flags ? status : 8'h00;
        end
        // Irq follows visible flags one cycle late
        irq_d = |status[3:1];
    end

    // Card line pipeline
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            // Idle-high reset so no false detect change follows release
            sync1_q <= 5'h1F;
            sync2_q <= 5'h1F;
            last_q  <= 5'h1F;
        end
        else
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            last_q  <= last_d;
        end
    end

    // Change flags
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            flag_q <= 3'h0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    // Registers, read port and request line
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ctrl_q  <= RST_INT_GEN_CTRL;
            cfg_q   <= RST_CSC_CONFIG;
            glob_q  <= RST_GLOBAL_CTRL;
            rdata_q <= 8'h00;
            ack_q   <= 1'h0;
            irq_q   <= 1'h0;
        end
        else
        begin
            ctrl_q  <= ctrl_d;
            cfg_q   <= cfg_d;
            glob_q  <= glob_d;
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
            irq_q   <= irq_d;
        end
    end

    assign o_reg_rdata              = rdata_q;
    assign o_reg_ack                = ack_q;
    assign o_card_status_change_irq = irq_q;
    assign o_status_irq_to_host_bus = ctrl_q[BIT_STATUS_IRQ_TO_HOST];
    assign o_irq_select             = cfg_q[7:SEL_LSB];

endmodule : card_status_change_flags
`default_nettype wire

//--- hw/csc_flags_pkg.sv
// Constants for the socket status-change flag block
`default_nettype none
package csc_flags_pkg;
    // Register offsets within the socket register window
    localparam logic [11:0] OFF_INT_GEN_CTRL = 12'h803;
    localparam logic [11:0] OFF_CSC_FLAGS    = 12'h804;
    localparam logic [11:0] OFF_CSC_CONFIG   = 12'h805;
    localparam logic [11:0] OFF_GLOBAL_CTRL  = 12'h81E;
    // Legacy index space, socket A values; socket B adds the stride
    localparam logic [7:0]  IDX_INT_GEN_CTRL = 8'h03;
    localparam logic [7:0]  IDX_CSC_FLAGS    = 8'h04;
    localparam logic [7:0]  IDX_CSC_CONFIG   = 8'h05;
    localparam logic [7:0]  IDX_GLOBAL_CTRL  = 8'h1E;
    localparam logic [7:0]  IDX_SOCKET_B     = 8'h40;
    // Reset values
    localparam logic [7:0]  RST_INT_GEN_CTRL = 8'h00;
    localparam logic [7:0]  RST_CSC_CONFIG   = 8'h00;
    localparam logic [7:0]  RST_GLOBAL_CTRL  = 8'h00;
    // Field positions
    localparam int BIT_RING_FUNCTION_ENABLE = 7;
    localparam int BIT_SOCKET_CARD_KIND     = 5;
    localparam int BIT_STATUS_IRQ_TO_HOST   = 4;
    localparam int BIT_CLEAR_MODE_W1C       = 2;
    localparam int BIT_CARD_DETECT_CHANGE   = 3;
    localparam int BIT_READY_RISE           = 2;
    localparam int BIT_BATTERY_LOW          = 1;
    localparam int BIT_BATTERY_DEAD         = 0;
    localparam int SEL_LSB                  = 4;
    // Synchroniser depth for card lines
    localparam int SYNC_STAGES              = 2;
endpackage : csc_flags_pkg
`default_nettype wire

//--- verif/card_model.sv
// Behavioural 16-bit card driving its status lines
`default_nettype none
module card_model (
    input  wire logic       i_seated,
    input  wire logic [2:0] i_cond,
    output logic      [4:0] o_lines
);
    timeunit 1ns;
    timeprecision 1ns;
    // Both detect pins follow seating; a half-seated card is not modelled
    assign o_lines = {!i_seated, !i_seated, i_cond[2], !i_cond[1], !i_cond[0]};
endmodule : card_model
`default_nettype wire

//--- verif/card_status_change_flags_monitor.sv
// Checker for the register port and routing outputs
`default_nettype none
module card_status_change_flags_monitor
    import csc_flags_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_reset,
    input wire logic        i_reg_legacy,
    input wire logic [11:0] i_reg_addr,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        o_reg_ack,
    input wire logic        o_status_irq_to_host_bus,
    input wire logic [3:0]  o_irq_select
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);
    chk_flag_top_zero: assert property (i_reg_rd && !i_reg_legacy
        && i_reg_addr == OFF_CSC_FLAGS |=> o_reg_rdata[7:4] == 4'h0) else $error("top bits set");
    chk_ack_follows: assert property (1'b1
        |=> o_reg_ack == $past(i_reg_rd || i_reg_wr)) else $error("ack timing wrong");
    chk_unmapped_zero: assert property (i_reg_rd && !i_reg_legacy
        && i_reg_addr == 12'h7FF |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
    chk_rdata_holds: assert property (!i_reg_rd
        |=> $stable(o_reg_rdata)) else $error("read data moved");
    chk_cfg_window: assert property (i_reg_wr && !i_reg_legacy && i_reg_addr == OFF_CSC_CONFIG
        ##1 !i_reg_wr ##1 i_reg_rd && !i_reg_legacy && i_reg_addr == OFF_CSC_CONFIG
        |=> o_reg_rdata == $past(i_reg_wdata, 3)) else $error("config readback wrong");
    chk_cfg_legacy: assert property (i_reg_wr && i_reg_legacy && i_reg_addr == 12'h005
        ##1 !i_reg_wr ##1 i_reg_rd && i_reg_legacy && i_reg_addr == 12'h005
        |=> o_reg_rdata == $past(i_reg_wdata, 3)) else $error("legacy config readback wrong");
    chk_select_cause: assert property ($changed(o_irq_select)
        |-> $past(i_reg_wr) || $past(i_reg_wr, 2)) else $error("select moved unasked");
    chk_route_cause: assert property ($changed(o_status_irq_to_host_bus)
        |-> $past(i_reg_wr) || $past(i_reg_wr, 2)) else $error("route moved unasked");
endmodule : card_status_change_flags_monitor
bind card_status_change_flags card_status_change_flags_monitor u_card_status_change_flags_monitor (
    .i_ref_clk, .i_reset, .i_reg_legacy, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
    .o_reg_rdata, .o_reg_ack, .o_status_irq_to_host_bus, .o_irq_select);
`default_nettype wire

//--- verif/test_card_status_change_flags.sv
// Self-checking bench for the socket status-change flag block
`default_nettype none
module test_card_status_change_flags
    import csc_flags_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_ref_clk = 1'b0, i_reset = 1'b1, i_reg_legacy = 1'b0;
    logic        i_reg_wr = 1'b0, i_reg_rd = 1'b0, seated = 1'b0;
    logic [11:0] i_reg_addr = 12'h000;
    logic [7:0]  i_reg_wdata = 8'h00, o_reg_rdata;
    logic [3:0]  o_irq_select;
    logic [2:0]  cond = 3'h0;
    logic [4:0]  lines;
    logic        o_reg_ack, o_card_status_change_irq, o_status_irq_to_host_bus;
    int          miscompares = 0, compares = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    card_model u_card_model (.i_seated(seated), .i_cond(cond), .o_lines(lines));
    card_status_change_flags u_card_status_change_flags (.i_ref_clk, .i_reset, .i_reg_legacy,
        .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .o_reg_ack,
        .i_card_detect1_n(lines[4]), .i_card_detect2_n(lines[3]), .i_ready(lines[2]),
        .i_battery_warn_n(lines[1]), .i_stschg_ring_n(lines[0]), .o_card_status_change_irq,
        .o_status_irq_to_host_bus, .o_irq_select);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = {w, !w, a, d};
        @(negedge i_ref_clk);
        {i_reg_wr, i_reg_rd} = 2'b00;
        chk({7'h0, o_reg_ack}, 8'h01);
    endtask : acc
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(o_reg_rdata, e);
    endtask : rdc
    // Card lines need three edges to show; six leaves margin for the request line
    task automatic idle();
        repeat (6) @(negedge i_ref_clk);
    endtask : idle
    task automatic t_reset();
        rdc(OFF_INT_GEN_CTRL, RST_INT_GEN_CTRL);
        rdc(OFF_CSC_CONFIG, RST_CSC_CONFIG);
        rdc(12'h7FF, 8'h00);
    endtask : t_reset
    // Reset in mid-run must bring the control, configuration and global registers and both routing outputs back
    task automatic t_rerun();
        @(negedge i_ref_clk);
        i_reset = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        chk({4'h0, o_irq_select}, 8'h00);
        chk({7'h0, o_status_irq_to_host_bus}, 8'h00);
        i_reset = 1'b0;
        rdc(OFF_CSC_CONFIG, RST_CSC_CONFIG);
        rdc(OFF_GLOBAL_CTRL, RST_GLOBAL_CTRL);
        rdc(OFF_INT_GEN_CTRL, RST_INT_GEN_CTRL);
    endtask : t_rerun
    task automatic t_mask();
        acc(1'b1, OFF_CSC_CONFIG, 8'h07);
        rdc(OFF_CSC_CONFIG, 8'h07);
        seated = 1'b1;
        idle();
        acc(1'b1, OFF_CSC_CONFIG, 8'h0F);
        rdc(OFF_CSC_FLAGS, 8'h00);
    endtask : t_mask
    task automatic t_detect();
        seated = 1'b0;
        idle();
        chk({7'h0, o_card_status_change_irq}, 8'h01);
        seated = 1'b1;
        idle();
        rdc(OFF_CSC_FLAGS, 8'h08);
        rdc(OFF_CSC_FLAGS, 8'h00);
        // Request line drops one edge after the clearing read
        @(negedge i_ref_clk);
        chk({7'h0, o_card_status_change_irq}, 8'h00);
    endtask : t_detect
    task automatic t_kinds();
        cond = 3'b100;
        idle();
        cond = 3'b000;
        idle();
        rdc(OFF_CSC_FLAGS, 8'h04);
        acc(1'b1, OFF_INT_GEN_CTRL, 8'h20);
        cond = 3'b111;
        idle();
        rdc(OFF_CSC_FLAGS, 8'h00);
        acc(1'b1, OFF_INT_GEN_CTRL, 8'hA0);
        rdc(OFF_CSC_FLAGS, 8'h01);
        acc(1'b1, OFF_INT_GEN_CTRL, 8'h00);
        cond = 3'b011;
        idle();
        rdc(OFF_CSC_FLAGS, 8'h03);
        cond = 3'b000;
        idle();
        rdc(OFF_CSC_FLAGS, 8'h02);
    endtask : t_kinds
    task automatic t_w1c();
        i_reg_legacy = 1'b1;
        acc(1'b1, 12'h01E, 8'h04);
        i_reg_legacy = 1'b0;
        seated = 1'b0;
        idle();
        rdc(OFF_CSC_FLAGS, 8'h08);
        rdc(OFF_CSC_FLAGS, 8'h08);
        acc(1'b1, OFF_CSC_FLAGS, 8'h08);
        rdc(OFF_CSC_FLAGS, 8'h00);
    endtask : t_w1c
    task automatic t_route();
        i_reg_legacy = 1'b1;
        acc(1'b1, 12'h005, 8'hA3);
        rdc(12'h005, 8'hA3);
        acc(1'b1, 12'h003, 8'h10);
        idle();
        chk({4'h0, o_irq_select}, 8'h0A);
        chk({7'h0, o_status_irq_to_host_bus}, 8'h01);
        i_reg_legacy = 1'b0;
    endtask : t_route
    task automatic end_sim();
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (12) @(negedge i_ref_clk);
        i_reset = 1'b0;
        t_reset();
        t_mask();
        t_detect();
        t_kinds();
        t_w1c();
        t_route();
        t_rerun();
        end_sim();
    end
    // The sequence needs well under a thousand cycles
    initial
    begin
        #50000;
        miscompares++;
        end_sim();
    end
endmodule : test_card_status_change_flags
`default_nettype wire
